// [inc/psc_map.svh]
// register map, field positions, reset values and timing counts of the strap loader
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

// axi4-lite address width and register byte offsets
`define PSC_AXI_AW 8
`define PSC_CTRL_OFF 8'h00
`define PSC_ADV_OFF 8'h10
`define PSC_STAT_OFF 8'h20

// control register fields
`define PSC_CTRL_RST_BIT 15
`define PSC_CTRL_SPD_BIT 13
`define PSC_CTRL_ANEG_BIT 12
`define PSC_CTRL_PD_BIT 11
`define PSC_CTRL_ISO_BIT 10
`define PSC_CTRL_DUP_BIT 8
`define PSC_CTRL_WMASK 16'h3d00
`define PSC_CTRL_RST_VAL 16'h3100

// advertisement register fields
`define PSC_ADV_CAP_LSB 5
`define PSC_ADV_WMASK 16'h01e0
`define PSC_ADV_RST_VAL 16'h01e1

// status register fields
`define PSC_STAT_MODE_LSB 5
`define PSC_STAT_RUN_BIT 8
`define PSC_STAT_PD_BIT 9
`define PSC_STAT_BUSY_BIT 10

// bus responses
`define PSC_RESP_OKAY 2'h0
`define PSC_RESP_SLVERR 2'h2

// scrambler seed filler below the station address
`define PSC_SEED_FILL 6'h01

// timing: reset extension and management clock limit
`define PSC_CLK_MHZ 100
`define PSC_SWRST_US 256
`define PSC_SWRST_CYCLES (`PSC_SWRST_US * `PSC_CLK_MHZ)
`define PSC_MDC_MIN_NS 400

`endif

// [inc/psc_pkg.sv]
// types shared by the strap loader modules
`default_nettype none
package psc_pkg;

  // operating-select strap codes
  typedef enum logic [2:0] {
    PSC_M10_HALF = 3'h0,
    PSC_M10_FULL = 3'h1,
    PSC_M100_HALF = 3'h2,
    PSC_M100_FULL = 3'h3,
    PSC_MAN_100_HALF = 3'h4,
    PSC_MREPEATER = 3'h5,
    PSC_MPOWER_DOWN = 3'h6,
    PSC_MALL_CAPABLE = 3'h7
  } psc_mode_t;

  // configuration sequencer states
  typedef enum logic [1:0] {
    PSC_LOAD,
    PSC_RUN,
    PSC_HOLD,
    PSC_DOWN
  } psc_state_t;

endpackage : psc_pkg
`default_nettype wire

// [logic/psc_reset_stretch.sv]
// reset extension counter for soft and power-down resets
`include "psc_map.svh"
`default_nettype none
module psc_reset_stretch
  import psc_pkg::*;
#(
  parameter int CYCLES = `PSC_SWRST_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  output logic busy
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count;

  // count down from the full extension, restart wins over the count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (start) begin
      count <= CW'(CYCLES);
    end else if (count != '0) begin
      count <= count - CW'(1);
    end
  end

  assign busy = (count != '0);

  property p_stretch_holds;
    @(posedge clk) disable iff (!rst_n)
    start |=> busy [*8];
  endproperty
  a_stretch_holds: assert property (p_stretch_holds)
    else $error("reset extension ended too early");

endmodule : psc_reset_stretch
`default_nettype wire

// [logic/psc_strap_loader.sv]
// strap capture and reset-time configuration of a 10/100 phy, axi4-lite registers
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`include "psc_map.svh"
`default_nettype none
module psc_strap_loader
  import psc_pkg::*;
#(
  parameter int STRETCH_CYCLES = `PSC_SWRST_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // straps from the board
  input wire logic [4:0] station_address_straps,
  input wire logic [2:0] mode_straps,
  // management frame address check
  input wire logic mgmt_frame_valid,
  input wire logic [4:0] mgmt_frame_addr,
  output logic mgmt_frame_accept,
  // configuration towards the datapath
  output logic [4:0] station_address,
  output logic [10:0] scrambler_seed,
  output logic speed_100,
  output logic autoneg_enable,
  output logic full_duplex,
  output logic isolate,
  output logic [3:0] adv_caps,
  output logic repeater_mode,
  output logic crs_on_transmit,
  output logic powered_down,
  output logic internal_reset,
  // axi4-lite write address
  input wire logic [`PSC_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [`PSC_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic rst_r1;
  logic rst_n;
  logic [4:0] addr_s1;
  logic [4:0] addr_s2;
  logic [2:0] mode_s1;
  logic [2:0] mode_s2;
  psc_mode_t mode_q;
  psc_state_t state;
  psc_state_t next_state;
  logic [15:0] ctrl;
  logic [15:0] adv;
  logic [31:0] preset;
  logic wr_fire;
  logic [15:0] wr_val;
  logic ctrl_wr;
  logic adv_wr;
  logic sw_rst_req;
  logic pd_clear;
  logic strap_pd;
  logic reload;
  logic busy;
  logic stretch_start;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_r1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_r1 <= 1'b1;
      rst_n <= rst_r1;
    end
  end

  // strap pins cross into the clock domain, first stage read only by second
  // no reset here: the stages must already hold the straps at the load edge
  always_ff @(posedge ref_clk) begin
    addr_s1 <= station_address_straps;
    addr_s2 <= addr_s1;
    mode_s1 <= mode_straps;
    mode_s2 <= mode_s1;
  end

  // straps steady, so sampling after release sees the settled level
  // capture address once, at first edge after release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      station_address <= 5'h00;
    end else if (state == PSC_LOAD) begin
      station_address <= addr_s2;
    end
  end

  // mode recaptured only to leave strap power-down by soft reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= PSC_M10_HALF;
    end else if (state == PSC_LOAD || reload) begin
      mode_q <= psc_mode_t'(mode_s2);
    end
  end

  assign strap_pd = (mode_q == PSC_MPOWER_DOWN);

  // scrambler seed differs between neighbours by station address
  assign scrambler_seed = {station_address, `PSC_SEED_FILL};

  // strap decoding into control and advertisement presets
  always_comb begin
    logic [15:0] c;
    logic [15:0] a;
    logic [3:0] f;
    c = `PSC_CTRL_RST_VAL;
    a = `PSC_ADV_RST_VAL;
    f = {c[`PSC_CTRL_SPD_BIT], c[`PSC_CTRL_ANEG_BIT], c[`PSC_CTRL_ISO_BIT],
         c[`PSC_CTRL_DUP_BIT]};
    unique case (psc_mode_t'(mode_s2))
      PSC_M10_HALF: f = 4'h0;
      PSC_M10_FULL: f = 4'h1;
      PSC_M100_HALF: f = 4'h8;
      PSC_M100_FULL: f = 4'h9;
      PSC_MAN_100_HALF, PSC_MREPEATER: begin
        f = 4'hc;
        a[`PSC_ADV_CAP_LSB+:4] = 4'h4;
      end
      PSC_MPOWER_DOWN: c[`PSC_CTRL_PD_BIT] = 1'b1;
      // speed and duplex keep their defaults
      PSC_MALL_CAPABLE: begin
        f[2] = 1'b1;
        f[1] = 1'b0;
        a[`PSC_ADV_CAP_LSB+:4] = 4'hf;
      end
    endcase
    c[`PSC_CTRL_SPD_BIT] = f[3];
    c[`PSC_CTRL_ANEG_BIT] = f[2];
    c[`PSC_CTRL_ISO_BIT] = f[1];
    c[`PSC_CTRL_DUP_BIT] = f[0];
    preset = {c, a};
  end

  // axi write: address and data taken together, one outstanding response
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign ctrl_wr = wr_fire && (s_axi_awaddr == `PSC_CTRL_OFF) && (state != PSC_LOAD);
  assign adv_wr = wr_fire && (s_axi_awaddr == `PSC_ADV_OFF) && (state != PSC_LOAD);

  // byte strobes merge onto the current value of the addressed register
  always_comb begin
    logic [15:0] cur;
    cur = (s_axi_awaddr == `PSC_ADV_OFF) ? adv : ctrl;
    wr_val[7:0] = s_axi_wstrb[0] ? s_axi_wdata[7:0] : cur[7:0];
    wr_val[15:8] = s_axi_wstrb[1] ? s_axi_wdata[15:8] : cur[15:8];
  end

  // writing one to bit 15 requests the soft reset
  assign sw_rst_req = ctrl_wr && s_axi_wstrb[1] && s_axi_wdata[`PSC_CTRL_RST_BIT];
  // clearing the power-down bit while down
  assign pd_clear = ctrl_wr && !wr_val[`PSC_CTRL_PD_BIT] && (state == PSC_DOWN);
  // new straps plus soft reset leave strap power-down
  assign reload = sw_rst_req && strap_pd && (mode_s2 != PSC_MPOWER_DOWN);

  // control and advertisement load from straps at hardware release
  // soft reset leaves both registers as they stand, unless it reloads them from new straps out of strap power-down
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `PSC_CTRL_RST_VAL;
      adv <= `PSC_ADV_RST_VAL;
    end else if (state == PSC_LOAD || reload) begin
      ctrl <= preset[31:16];
      adv <= preset[15:0];
    end else begin
      if (ctrl_wr) begin
        ctrl <= (ctrl & ~`PSC_CTRL_WMASK) | (wr_val & `PSC_CTRL_WMASK);
        // power-down strap pins bit 11 high
        if (strap_pd) begin
          ctrl[`PSC_CTRL_PD_BIT] <= 1'b1;
        end
      end
      if (adv_wr) begin
        adv <= (adv & ~`PSC_ADV_WMASK) | (wr_val & `PSC_ADV_WMASK);
      end
    end
  end

  // configuration sequencer
  always_comb begin
    next_state = state;
    stretch_start = 1'b0;
    unique case (state)
      PSC_LOAD: next_state = PSC_RUN;
      PSC_RUN: begin
        // soft reset enters the held reset
        if (sw_rst_req) begin
          next_state = PSC_HOLD;
          stretch_start = 1'b1;
        // power-down bit parks everything but management
        end else if (ctrl[`PSC_CTRL_PD_BIT]) begin
          next_state = PSC_DOWN;
        end
      end
      PSC_HOLD: begin
        if (!busy) begin
          next_state = PSC_RUN;
        end
      end
      PSC_DOWN: begin
        // wake up with an automatic reset
        if (sw_rst_req || pd_clear || !ctrl[`PSC_CTRL_PD_BIT]) begin
          next_state = PSC_HOLD;
          stretch_start = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= PSC_LOAD;
    end else begin
      state <= next_state;
    end
  end

  psc_reset_stretch #(
    .CYCLES(STRETCH_CYCLES)
  ) u_stretch (
    .clk(ref_clk),
    .rst_n(rst_n),
    .start(stretch_start),
    .busy(busy)
  );

  // datapath configuration straight from register bits, repeater mode from the captured strap code
  assign speed_100 = ctrl[`PSC_CTRL_SPD_BIT];
  assign autoneg_enable = ctrl[`PSC_CTRL_ANEG_BIT];
  assign full_duplex = ctrl[`PSC_CTRL_DUP_BIT];
  assign isolate = ctrl[`PSC_CTRL_ISO_BIT];
  assign adv_caps = adv[`PSC_ADV_CAP_LSB+:4];
  assign repeater_mode = (mode_q == PSC_MREPEATER);
  // carrier on transmit only for half duplex, never as repeater
  assign crs_on_transmit = !full_duplex && !repeater_mode;
  assign powered_down = (state == PSC_DOWN);
  assign internal_reset = (state == PSC_HOLD) || (state == PSC_LOAD);

  // answer only frames for this station
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_frame_accept <= 1'b0;
    end else begin
      mgmt_frame_accept <= mgmt_frame_valid && (mgmt_frame_addr == station_address)
                           && (state != PSC_LOAD);
    end
  end

  // write response one cycle after the take
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PSC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (s_axi_awaddr == `PSC_CTRL_OFF || s_axi_awaddr == `PSC_ADV_OFF ||
                      s_axi_awaddr == `PSC_STAT_OFF) ? `PSC_RESP_OKAY : `PSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read data; bit 15 of control reads one while the reset is held
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PSC_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `PSC_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      unique case (s_axi_araddr)
        `PSC_CTRL_OFF: s_axi_rdata[15:0] <= {state == PSC_HOLD, ctrl[14:0]};
        `PSC_ADV_OFF: s_axi_rdata[15:0] <= adv;
        `PSC_STAT_OFF: begin
          s_axi_rdata[4:0] <= station_address;
          s_axi_rdata[`PSC_STAT_MODE_LSB+:3] <= mode_q;
          s_axi_rdata[`PSC_STAT_RUN_BIT] <= (state == PSC_RUN);
          s_axi_rdata[`PSC_STAT_PD_BIT] <= powered_down;
          s_axi_rdata[`PSC_STAT_BUSY_BIT] <= internal_reset;
        end
        default: s_axi_rresp <= `PSC_RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  property p_addr_capture;
    @(posedge ref_clk) disable iff (!rst_n)
    state == PSC_LOAD |=> station_address == $past(addr_s2);
  endproperty
  a_addr_capture: assert property (p_addr_capture)
    else $error("station address not captured at release");

  property p_addr_kept;
    @(posedge ref_clk) disable iff (!rst_n)
    state != PSC_LOAD |=> $stable(station_address);
  endproperty
  a_addr_kept: assert property (p_addr_kept)
    else $error("station address changed after capture");

  property p_frame_filter;
    @(posedge ref_clk) disable iff (!rst_n)
    mgmt_frame_valid && state != PSC_LOAD |=>
      mgmt_frame_accept == ($past(mgmt_frame_addr) == station_address);
  endproperty
  a_frame_filter: assert property (p_frame_filter)
    else $error("management frame address filter wrong");

  property p_mode_10_full;
    @(posedge ref_clk) disable iff (!rst_n)
    state == PSC_LOAD && mode_s2 == PSC_M10_FULL |=>
      {speed_100, autoneg_enable, isolate, full_duplex} == 4'h1 && adv == `PSC_ADV_RST_VAL;
  endproperty
  a_mode_10_full: assert property (p_mode_10_full)
    else $error("mode 001 preset wrong");

  property p_mode_100_half;
    @(posedge ref_clk) disable iff (!rst_n)
    state == PSC_LOAD && mode_s2 == PSC_M100_HALF |=>
      {speed_100, autoneg_enable, isolate, full_duplex} == 4'h8 && crs_on_transmit;
  endproperty
  a_mode_100_half: assert property (p_mode_100_half)
    else $error("mode 010 preset wrong");

  property p_mode_repeater;
    @(posedge ref_clk) disable iff (!rst_n)
    state == PSC_LOAD && mode_s2 == PSC_MREPEATER |=>
      adv_caps == 4'h4 && autoneg_enable && repeater_mode && !crs_on_transmit;
  endproperty
  a_mode_repeater: assert property (p_mode_repeater)
    else $error("mode 101 preset wrong");

  property p_mode_all;
    @(posedge ref_clk) disable iff (!rst_n)
    state == PSC_LOAD && mode_s2 == PSC_MALL_CAPABLE |=>
      adv_caps == 4'hf && autoneg_enable && !isolate;
  endproperty
  a_mode_all: assert property (p_mode_all)
    else $error("mode 111 preset wrong");

  property p_strap_down;
    @(posedge ref_clk) disable iff (!rst_n)
    state == PSC_LOAD && mode_s2 == PSC_MPOWER_DOWN |=> ##1 powered_down;
  endproperty
  a_strap_down: assert property (p_strap_down)
    else $error("power-down strap did not power down");

  property p_soft_reset;
    @(posedge ref_clk) disable iff (!rst_n)
    state == PSC_RUN && sw_rst_req |=> internal_reset && $stable(adv) ##1 internal_reset;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset not held or registers changed");

  property p_wake;
    @(posedge ref_clk) disable iff (!rst_n)
    pd_clear && !strap_pd |=> state == PSC_HOLD;
  endproperty
  a_wake: assert property (p_wake)
    else $error("power-up reset not started");

endmodule : psc_strap_loader
`default_nettype wire

// [tb/psc_strap_model.sv]
// board side of the loader: strap levels and management frame addresses
`default_nettype none
module psc_strap_model (
  // clock
  input wire logic clk,
  // strap levels towards the loader
  output logic [4:0] station_address_straps,
  output logic [2:0] mode_straps,
  // management frame addresses
  output logic mgmt_frame_valid,
  output logic [4:0] mgmt_frame_addr
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    station_address_straps = 5'h00;
    mode_straps = 3'h7;
    mgmt_frame_valid = 1'b0;
    mgmt_frame_addr = 5'h1f;
  end

  // levels only change here, and then stay put
  task automatic set_straps(input logic [4:0] a, input logic [2:0] m);
    station_address_straps <= a;
    mode_straps <= m;
  endtask : set_straps

  // frames spaced 40 cycles, the 400 ns clock limit
  task automatic frame(input logic [4:0] a);
    mgmt_frame_valid <= 1'b1;
    mgmt_frame_addr <= a;
    @(posedge clk);
    mgmt_frame_valid <= 1'b0;
    // idle address inverted so a stale copy cannot match by luck
    mgmt_frame_addr <= ~a;
    repeat (39) @(posedge clk);
  endtask : frame
endmodule : psc_strap_model
`default_nettype wire

// [tb/tb.sv]
// self-checking bench of the strap loader
`include "psc_map.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int stretch = 16;
  localparam logic [15:0] ctrl_exp [8] = '{16'h0000, 16'h0100, 16'h2000, 16'h2100,
    16'h3000, 16'h3000, 16'h3900, 16'h3100};
  localparam logic [15:0] adv_exp [8] = '{16'h01e1, 16'h01e1, 16'h01e1, 16'h01e1,
    16'h0081, 16'h0081, 16'h01e1, 16'h01e1};
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] station_address_straps, mgmt_frame_addr, station_address;
  logic [2:0] mode_straps;
  logic mgmt_frame_valid, mgmt_frame_accept, speed_100, autoneg_enable, full_duplex;
  logic isolate, repeater_mode, crs_on_transmit, powered_down, internal_reset;
  logic [10:0] scrambler_seed;
  logic [3:0] adv_caps;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 32'hd3e87fa2;
  logic [33:0] rq [$];
  logic fq [$];
  logic fv_d = 1'b0;

  always #5 ref_clk = ~ref_clk;

  psc_strap_loader #(.STRETCH_CYCLES(stretch)) uut (.ref_clk, .arst_n,
    .station_address_straps, .mode_straps, .mgmt_frame_valid, .mgmt_frame_addr,
    .mgmt_frame_accept, .station_address, .scrambler_seed, .speed_100, .autoneg_enable,
    .full_duplex, .isolate, .adv_caps, .repeater_mode, .crs_on_transmit, .powered_down,
    .internal_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  psc_strap_model strap (.clk(ref_clk), .station_address_straps, .mode_straps,
    .mgmt_frame_valid, .mgmt_frame_addr);

  // one comparison, counted
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask : chk

  // verdict and end of run
  task automatic final_report;
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  // write: address and data together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= ({$random(seed)} & 32'hffff0000) | {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge ref_clk);
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask : axw

  // read: expectation noted first, the monitor compares
  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : axr

  // hardware reset with straps settled long before release
  task automatic hwrst(input logic [2:0] m, input logic [4:0] a);
    strap.set_straps(a, m);
    arst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask : hwrst

  // length of the internal reset pulse in cycles
  task automatic wait_rst(output int cnt);
    cnt = 0;
    while (!internal_reset) @(posedge ref_clk);
    while (internal_reset) begin
      @(posedge ref_clk);
      cnt++;
    end
  endtask : wait_rst

  // monitor: oldest note against each result as it appears
  always @(posedge ref_clk) begin
    fv_d <= mgmt_frame_valid;
    if (s_axi_rvalid && s_axi_rready) chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (fv_d) chk("accept", fq.pop_front(), mgmt_frame_accept);
  end

  initial begin
    int cnt;
    logic [4:0] a;
    logic [4:0] r;
    logic [15:0] ce;
    logic [15:0] ae;
    // every strap code after its own hardware reset
    for (int m = 0; m < 8; m++) begin
      a = $random(seed);
      hwrst(m[2:0], a);
      ce = ctrl_exp[m];
      ae = adv_exp[m];
      chk("addr", {a, a, `PSC_SEED_FILL}, {station_address, scrambler_seed});
      axr(`PSC_STAT_OFF, {23'h0, 1'b0, m == 6, m != 6, m[2:0], a});
      if (m == 6) chk("pd", 1, powered_down);
      else begin
        axr(`PSC_CTRL_OFF, {18'h0, ce});
        axr(`PSC_ADV_OFF, {18'h0, ae});
        chk("cfg", {ce[13], ce[12], ce[10], ce[8], ae[8:5], m == 5, !ce[8] && m != 5},
          {speed_100, autoneg_enable, isolate, full_duplex, adv_caps, repeater_mode,
          crs_on_transmit});
      end
    end
    // straps moved after release leave the captured address alone
    strap.set_straps(~a, 3'h0);
    repeat (3) @(posedge ref_clk);
    chk("addr_kept", a, station_address);
    // frames: own address, neighbour, then random ones
    fq.push_back(1'b1);
    strap.frame(a);
    fq.push_back(1'b0);
    strap.frame(a ^ 5'h01);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      fq.push_back(r == a);
      strap.frame(r);
    end
    // unmapped place and read-only status
    axr(8'h30, {`PSC_RESP_SLVERR, 32'h0});
    axw(8'h30, 16'h1234, `PSC_RESP_SLVERR);
    axw(`PSC_STAT_OFF, 16'hffff, `PSC_RESP_OKAY);
    axr(`PSC_STAT_OFF, {23'h0, 3'h1, 3'h7, a});
    // soft reset keeps registers although mode straps now read 000
    axw(`PSC_CTRL_OFF, 16'h2100, `PSC_RESP_OKAY);
    axw(`PSC_CTRL_OFF, 16'ha100, `PSC_RESP_OKAY);
    wait_rst(cnt);
    chk("stretch", 1, cnt >= stretch && cnt <= stretch + 3);
    axr(`PSC_CTRL_OFF, {18'h0, 16'h2100});
    axr(`PSC_ADV_OFF, {18'h0, 16'h01e1});
    chk("cfg_kept", 4'h9, {speed_100, autoneg_enable, isolate, full_duplex});
    // power down by bit 11, then back up through a reset
    axw(`PSC_CTRL_OFF, 16'h2900, `PSC_RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    chk("pd_on", 1, powered_down);
    axw(`PSC_CTRL_OFF, 16'h2100, `PSC_RESP_OKAY);
    wait_rst(cnt);
    chk("pd_off", {1'b0, 1'b1}, {powered_down, cnt >= stretch && cnt <= stretch + 3});
    // power-down code left by new straps and a soft reset
    hwrst(3'h6, a);
    strap.set_straps(a, 3'h3);
    repeat (3) @(posedge ref_clk);
    axw(`PSC_CTRL_OFF, 16'h8000, `PSC_RESP_OKAY);
    wait_rst(cnt);
    chk("wake", 0, powered_down);
    axr(`PSC_CTRL_OFF, {18'h0, 16'h2100});
    axr(`PSC_STAT_OFF, {23'h0, 3'h1, 3'h3, a});
    final_report;
  end

  // watchdog: the whole sequence needs well under this many cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    final_report;
  end
endmodule : tb
`default_nettype wire
